/* ucs_pkg.sv */
`default_nettype none

package ucs_pkg;

    // Core clock and the fractional base tick that all derived rates come from
    localparam int unsigned CORE_CLK_HZ = 125_000_000;
    localparam int unsigned BASE_HZ     = 96_000_000;
    localparam int unsigned CORE_MHZ    = CORE_CLK_HZ / 1_000_000;
    localparam int unsigned BASE_MHZ    = BASE_HZ / 1_000_000;
    localparam logic [7:0]  ACC_MOD     = 8'(CORE_MHZ);
    localparam logic [7:0]  ACC_STEP    = 8'(BASE_MHZ);
    localparam logic [6:0]  ACC_RESET   = 7'h00;

    // Nominal processor clock timing in the 12 MHz setting
    localparam int unsigned CPU12_PERIOD_PS = 83_300;
    localparam int unsigned CPU12_ADJ_PS    = 20_800;

    // Base ticks per derived clock period
    localparam logic [7:0] DIV_24M  = 8'h04;
    localparam logic [7:0] DIV_12M  = 8'h08;
    localparam logic [7:0] DIV_1M5  = 8'h40;
    localparam logic [6:0] DIV_1M   = 7'h60;

    // A phase adjustment moves one edge by a quarter period
    localparam int unsigned ADJ_SHIFT = 2;

    localparam logic [7:0] CNT_RESET    = 8'h00;
    localparam logic [7:0] PERIOD_RESET = DIV_24M;

    typedef enum logic [1:0] {
        UCS_RATE_24M,
        UCS_RATE_12M,
        UCS_RATE_1M5
    } ucs_rate_t;

    typedef struct packed {
        logic cpu;
        logic timer;
        logic spi;
        logic adc;
        logic watchdog_timer;
    } ucs_clk_en_t;

    localparam ucs_clk_en_t CLK_EN_RESET = '{default: 1'b0};

endpackage : ucs_pkg

`default_nettype wire

/* ucs_clock_select.sv */
// Notes on behaviour
// - The processor clock is 1.5, 12 or 24 MHz, picked from USB speed and the doubling pin.
// - The processor clock comes from the USB clock logic, not straight from the crystal.
// - At 12 MHz the period averages 83.3 ns and single cycles may move by 20.8 ns.
// - The 1.5 MHz setting is eight times slower and 24 MHz twice as fast, each adjusted by a quarter period.
// - Full speed, pin low: processor and SPI 24 MHz, timer 12 MHz, ADC and watchdog 1 MHz.
// - Full speed, pin high: processor, timer and SPI 12 MHz, ADC and watchdog 1 MHz.
// - Low speed, pin low: processor and SPI 24 MHz, timer 12 MHz, ADC and watchdog 1 MHz.
// - Low speed, pin high: processor, timer and SPI 1.5 MHz, ADC and watchdog 1 MHz.
`timescale 1ns/1ns
`default_nettype none

module ucs_clock_select (
    input  wire logic                 core_clk,              // 125 MHz core clock
    input  wire logic                 rst_n,                 // Async reset, active low
    input  wire logic                 usb_full_speed,        // 1 full speed, 0 low speed
    input  wire logic                 clock_double_select_n, // Doubling select pin level
    input  wire logic                 phase_stretch,         // Separator asks a longer cycle
    input  wire logic                 phase_shrink,          // Separator asks a shorter cycle
    output var  ucs_pkg::ucs_clk_en_t clk_en,                // One-cycle clock enables
    output var  ucs_pkg::ucs_rate_t   cpu_rate               // Processor rate in force
);
    import ucs_pkg::*;

    if (BASE_HZ >= CORE_CLK_HZ) begin : g_rate_check
        $error("Base tick rate must be below the core clock rate");
    end

    function automatic ucs_rate_t rate_decode(input logic fs, input logic dbl_n);
        if (!dbl_n) begin
            rate_decode = UCS_RATE_24M;
        end else if (fs) begin
            rate_decode = UCS_RATE_12M;
        end else begin
            rate_decode = UCS_RATE_1M5;
        end
    endfunction : rate_decode

    function automatic logic [7:0] rate_div(input ucs_rate_t r);
        case (r)
            UCS_RATE_24M: rate_div = DIV_24M;
            UCS_RATE_12M: rate_div = DIV_12M;
            default:      rate_div = DIV_1M5;
        endcase
    endfunction : rate_div

    ////////////////////////////////////////////////////////////////////////////////
    // Fractional base tick: exact 96 MHz average, at most one core cycle of jitter

    logic [6:0] acc;
    logic [6:0] next_acc;
    logic       base_tick;
    logic [7:0] acc_sum;

    always_comb begin
        acc_sum   = {1'b0, acc} + ACC_STEP;
        base_tick = (acc_sum >= ACC_MOD);
        next_acc  = base_tick ? 7'(acc_sum - ACC_MOD) : acc_sum[6:0];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= ACC_RESET;
        end else begin
            acc <= next_acc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Processor clock divider with phase adjustment

    logic        loaded;
    logic        next_loaded;
    ucs_rate_t   next_rate;
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic [7:0]  period;
    logic [7:0]  next_period;
    logic        pend_stretch;
    logic        next_pend_stretch;
    logic        pend_shrink;
    logic        next_pend_shrink;
    logic        half;
    logic        next_half;
    logic        wrap;
    logic [7:0]  new_div;
    ucs_rate_t   new_rate;
    logic [6:0]  one_cnt;
    logic [6:0]  next_one_cnt;
    logic        one_tick;
    ucs_clk_en_t next_clk_en;

    always_comb begin
        next_loaded  = 1'b1;
        next_rate    = cpu_rate;
        next_cnt     = cnt;
        next_period  = period;
        next_half    = half;
        next_one_cnt = one_cnt;
        new_rate     = rate_decode(usb_full_speed, clock_double_select_n);
        new_div      = rate_div(new_rate);
        // The count runs on the base tick, not the crystal
        wrap         = loaded && base_tick && (cnt == period - 8'h01);
        one_tick     = loaded && base_tick && (one_cnt == DIV_1M - 7'h01);
        // A request that lands on the wrap is kept for the next one
        next_pend_stretch = (pend_stretch && !wrap) || phase_stretch;
        next_pend_shrink  = (pend_shrink && !wrap) || phase_shrink;
        if (!loaded) begin
            // First cycle after release: take the selection afresh
            next_rate   = new_rate;
            next_period = new_div;
            next_cnt    = CNT_RESET;
            next_half   = 1'b0;
        end else if (base_tick) begin
            next_one_cnt = one_tick ? 7'h00 : one_cnt + 7'h01;
            if (wrap) begin
                // Rate changes only at a period boundary, so no runt cycle appears
                next_cnt  = CNT_RESET;
                next_rate = new_rate;
                next_half = (new_rate == UCS_RATE_24M) ? !half : 1'b0;
                if (pend_stretch && !pend_shrink) begin
                    next_period = new_div + (new_div >> ADJ_SHIFT);
                end else if (pend_shrink && !pend_stretch) begin
                    next_period = new_div - (new_div >> ADJ_SHIFT);
                end else begin
                    next_period = new_div;
                end
            end else begin
                next_cnt = cnt + 8'h01;
            end
        end
        next_clk_en.cpu            = wrap;
        next_clk_en.spi            = wrap;
        // Timer is halved only when the processor runs at 24 MHz
        next_clk_en.timer          = wrap && (cpu_rate != UCS_RATE_24M || half);
        next_clk_en.adc            = one_tick;
        next_clk_en.watchdog_timer = one_tick;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loaded       <= 1'b0;
            cpu_rate     <= UCS_RATE_24M;
            cnt          <= CNT_RESET;
            period       <= PERIOD_RESET;
            pend_stretch <= 1'b0;
            pend_shrink  <= 1'b0;
            half         <= 1'b0;
            one_cnt      <= 7'h00;
            clk_en       <= CLK_EN_RESET;
        end else begin
            loaded       <= next_loaded;
            cpu_rate     <= next_rate;
            cnt          <= next_cnt;
            period       <= next_period;
            pend_stretch <= next_pend_stretch;
            pend_shrink  <= next_pend_shrink;
            half         <= next_half;
            one_cnt      <= next_one_cnt;
            clk_en       <= next_clk_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [7:0] cpu_gap;
    logic       cpu_seen;
    logic [7:0] one_gap;
    logic       one_seen;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_gap  <= 8'h00;
            cpu_seen <= 1'b0;
            one_gap  <= 8'h00;
            one_seen <= 1'b0;
        end else begin
            cpu_gap  <= clk_en.cpu ? 8'h00 : ((cpu_gap == 8'hff) ? cpu_gap : cpu_gap + 8'h01);
            cpu_seen <= cpu_seen || clk_en.cpu;
            one_gap  <= clk_en.adc ? 8'h00 : ((one_gap == 8'hff) ? one_gap : one_gap + 8'h01);
            one_seen <= one_seen || clk_en.adc;
        end
    end

    sequence s_released;
        !loaded ##1 loaded;
    endsequence

    a_reset_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_released |-> clk_en == CLK_EN_RESET && cpu_rate ==
            $past(rate_decode(usb_full_speed, clock_double_select_n)))
        else $error("Enables or rate wrong right after reset release");

    a_rate_select: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrap |=> cpu_rate == $past(rate_decode(usb_full_speed, clock_double_select_n)))
        else $error("Processor rate does not follow speed and doubling pin");

    a_from_base_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en.cpu |-> $past(base_tick))
        else $error("Processor enable not on a base tick");

    a_gap_12m: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en.cpu && cpu_seen && $past(cpu_rate) == UCS_RATE_12M
            |-> cpu_gap >= 8'h06 && cpu_gap <= 8'h0d)
        else $error("12 MHz period outside adjustment range");

    a_gap_24m: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en.cpu && cpu_seen && $past(cpu_rate) == UCS_RATE_24M
            |-> cpu_gap >= 8'h02 && cpu_gap <= 8'h06)
        else $error("24 MHz period outside adjustment range");

    a_gap_1m5: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en.cpu && cpu_seen && $past(cpu_rate) == UCS_RATE_1M5
            |-> cpu_gap >= 8'h3d && cpu_gap <= 8'h68)
        else $error("1.5 MHz period outside adjustment range");

    a_timer_half: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en.timer && $past(cpu_rate) == UCS_RATE_24M
            |-> clk_en.cpu ##1 (!clk_en.timer)[*3])
        else $error("Timer not at half the 24 MHz processor rate");

    a_timer_equal: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en.cpu && $past(cpu_rate) != UCS_RATE_24M |-> clk_en.timer && clk_en.spi)
        else $error("Timer or SPI not equal to processor rate");

    a_spi_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en.spi == clk_en.cpu)
        else $error("SPI enable differs from processor enable");

    a_one_mhz: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en.adc && one_seen |-> one_gap == 8'h7c && clk_en.watchdog_timer)
        else $error("ADC and watchdog enable not at 1 MHz");

endmodule : ucs_clock_select

`default_nettype wire

/* ucs_sep_model.sv */
`timescale 1ns/1ns
`default_nettype none

module ucs_sep_model (
    input  wire logic       core_clk,      // Core clock
    input  wire logic       rst_n,         // Async reset, active low
    input  wire logic [1:0] adj_mode,      // Bit 0 stretch, bit 1 shrink
    input  wire logic       cpu_tick,      // Processor enable seen from the block
    output var  logic       phase_stretch, // One-cycle longer-cycle request
    output var  logic       phase_shrink   // One-cycle shorter-cycle request
);
    logic next_stretch;
    logic next_shrink;

    // One correction per processor cycle, the most a separator ever asks
    always_comb begin
        next_stretch = adj_mode[0] & cpu_tick;
        next_shrink  = adj_mode[1] & cpu_tick;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_stretch <= 1'b0;
            phase_shrink  <= 1'b0;
        end else begin
            phase_stretch <= next_stretch;
            phase_shrink  <= next_shrink;
        end
    end
endmodule : ucs_sep_model

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
    import ucs_pkg::*;
    logic        core_clk              = 1'b0;
    logic        rst_n                 = 1'b0;
    logic        usb_full_speed        = 1'b1;
    logic        clock_double_select_n = 1'b0;
    logic [1:0]  adj_mode              = 2'h0;
    logic        phase_stretch;
    logic        phase_shrink;
    ucs_clk_en_t clk_en;
    ucs_rate_t   cpu_rate;
    int          error_cnt             = 0;
    int          checks                = 0;
    int          cnt [6];

    always #4 core_clk = ~core_clk;

    ucs_clock_select ucs_clock_select_inst (
        .core_clk(core_clk), .rst_n(rst_n), .usb_full_speed(usb_full_speed),
        .clock_double_select_n(clock_double_select_n), .phase_stretch(phase_stretch),
        .phase_shrink(phase_shrink), .clk_en(clk_en), .cpu_rate(cpu_rate));
    ucs_sep_model ucs_sep_model_inst (
        .core_clk(core_clk), .rst_n(rst_n), .adj_mode(adj_mode), .cpu_tick(clk_en.cpu),
        .phase_stretch(phase_stretch), .phase_shrink(phase_shrink));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Window edges cut a period, so one pulse either way is allowed
    task automatic check_near(input int seen, input int exp);
        check((seen >= exp - 1 && seen <= exp + 1) ? 16'(exp) : 16'(seen), 16'(exp));
    endtask : check_near

    task automatic set_mode(input logic fs, input logic pin, input ucs_rate_t rate);
        int n;
        @(posedge core_clk);
        #1;
        usb_full_speed        = fs;
        clock_double_select_n = pin;
        for (n = 0; n < 300 && cpu_rate !== rate; n++) @(negedge core_clk);
        if (n == 300) begin
            error_cnt++;
            complete_run();
        end else begin
            repeat (150) @(negedge core_clk);
        end
    endtask : set_mode

    // 1000 cycles hold exactly 768 base ticks and 8 slow periods
    task automatic measure;
        cnt = '{default: 0};
        repeat (1000) begin
            @(negedge core_clk);
            cnt[0] += int'(clk_en.cpu);
            cnt[1] += int'(clk_en.timer);
            cnt[2] += int'(clk_en.adc);
            cnt[3] += int'(clk_en.watchdog_timer);
            cnt[4] += int'(clk_en.spi !== clk_en.cpu);
        end
    endtask : measure

    ////////////////////////////////////////////////////////////////////////////////
    task automatic scen_modes;
        logic [1:0] m;
        ucs_rate_t  r [4] = '{UCS_RATE_24M, UCS_RATE_12M, UCS_RATE_24M, UCS_RATE_1M5};
        int         ec [4] = '{192, 96, 192, 12};
        int         et [4] = '{96, 96, 96, 12};
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            set_mode(~m[1], m[0], r[i]);
            measure();
            check(16'(cpu_rate), 16'(r[i]));
            check_near(cnt[0], ec[i]);
            check_near(cnt[1], et[i]);
            check(16'(cnt[2]), 16'h0008);
            check(16'(cnt[3]), 16'h0008);
            check(16'(cnt[4]), 16'h0000);
        end
    endtask : scen_modes

    task automatic scen_adjust;
        logic       fs [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        logic       pn [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic [1:0] md [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
        ucs_rate_t  r [5] = '{UCS_RATE_12M, UCS_RATE_12M, UCS_RATE_12M,
                              UCS_RATE_24M, UCS_RATE_1M5};
        int         ec [5] = '{77, 128, 96, 154, 16};
        for (int i = 0; i < 5; i++) begin
            adj_mode = md[i];
            set_mode(fs[i], pn[i], r[i]);
            measure();
            check_near(cnt[0], ec[i]);
            check(16'(cnt[2]), 16'h0008);
        end
        adj_mode = 2'h0;
    endtask : scen_adjust

    task automatic scen_reset;
        set_mode(1'b0, 1'b1, UCS_RATE_1M5);
        @(posedge core_clk);
        #1;
        rst_n = 1'b0;
        usb_full_speed = 1'b1;
        repeat (3) begin
            @(negedge core_clk);
            check(16'(clk_en), 16'(CLK_EN_RESET));
            check(16'(cpu_rate), 16'(UCS_RATE_24M));
        end
        @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        // The rate is only loaded on the first rising edge after release
        @(posedge core_clk);
        @(negedge core_clk);
        check(16'(clk_en), 16'(CLK_EN_RESET));
        check(16'(cpu_rate), 16'(UCS_RATE_12M));
        measure();
        check_near(cnt[0], 96);
    endtask : scen_reset

    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        scen_modes();
        scen_adjust();
        scen_reset();
        complete_run();
    end
endmodule : tb

`default_nettype wire
